// file: verilog/lmis_params.svh
`ifndef LMIS_PARAMS_SVH
`define LMIS_PARAMS_SVH

// register byte offsets
`define LMIS_OFF_INSTR 8'h00
`define LMIS_OFF_ACC 8'h04
`define LMIS_OFF_BANK 8'h08
`define LMIS_OFF_LATCH 8'h0c
`define LMIS_OFF_PTR0 8'h10
`define LMIS_OFF_PTR1 8'h14
`define LMIS_OFF_STATUS 8'h18
`define LMIS_OFF_MEM_ADDR 8'h1c
`define LMIS_OFF_MEM_DATA 8'h20

// reset values
`define LMIS_RST_INSTR 14'h0000
`define LMIS_RST_ACC 8'h00
`define LMIS_RST_BANK 5'h00
`define LMIS_RST_LATCH 7'h00
`define LMIS_RST_PTR 16'h0000
`define LMIS_RST_FLAGS 3'h0
`define LMIS_RST_MEM_ADDR 16'h0000

// status register field positions
`define LMIS_ST_FLAGS_LSB 0
`define LMIS_ST_FLAGS_MSB 2
`define LMIS_ST_UNSUP 8

// instruction field positions and opcode patterns
`define LMIS_IND_PATTERN 11'h003
`define LMIS_FILE_PATTERN 7'h01
`define LMIS_BANK_PATTERN 9'h001
`define LMIS_LATCH_PATTERN 7'h63
`define LMIS_ACC_PATTERN 6'h30
`define LMIS_OFS_PATTERN 7'h7f
`define LMIS_IND_SEL_BIT 2
`define LMIS_OFS_SEL_BIT 6

// file addresses that stand for the two indirect access ports
`define LMIS_PORT0_FILE 7'h00
`define LMIS_PORT1_FILE 7'h01

// bus responses
`define LMIS_RESP_OKAY 2'h0
`define LMIS_RESP_SLVERR 2'h2

`endif

// file: verilog/lmis_pkg.sv
package lmis_pkg;

    // decoded instruction kinds
    typedef enum logic [2:0] {
        LMIS_OP_NONE = 3'h0,
        LMIS_OP_BANK = 3'h1,
        LMIS_OP_LATCH = 3'h2,
        LMIS_OP_ACC = 3'h3,
        LMIS_OP_FILE = 3'h4,
        LMIS_OP_IND = 3'h5,
        LMIS_OP_OFS = 3'h6
    } lmis_op_e;

    // pointer_update_mode encodings
    typedef enum logic [1:0] {
        LMIS_PRE_INC = 2'h0,
        LMIS_PRE_DEC = 2'h1,
        LMIS_POST_INC = 2'h2,
        LMIS_POST_DEC = 2'h3
    } lmis_mode_e;

    // write channel states, gray along idle-exec-resp
    typedef enum logic [1:0] {
        LMIS_WS_IDLE = 2'b00,
        LMIS_WS_EXEC = 2'b01,
        LMIS_WS_RESP = 2'b11
    } lmis_wstate_e;

    // one decoded instruction word
    typedef struct packed {
        lmis_op_e op;
        logic [7:0] literal;
        logic ptr_sel;
        lmis_mode_e mode;
        logic [6:0] file_addr;
    } lmis_decoded_s;

    // one data memory write
    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [7:0] data;
    } lmis_mem_wr_s;

endpackage : lmis_pkg

// file: verilog/lmis_mem.sv
`timescale 1ns/100ps

module lmis_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port, data registered
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] cells [0:(1<<AW)-1];

    // write
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            cells[waddr] <= wdata;
        end
    end

    // registered read, old data on collision
    always_ff @(posedge clk)
    begin
        rdata <= cells[raddr];
    end

endmodule : lmis_mem

// file: verilog/lmis_core.sv
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "lmis_params.svh"

// Functional notes
// - loading the bank literal writes the 5-bit immediate (0..31) into bank_select_reg.
// - loading the bank literal changes no status flag.
// - loading the program latch literal writes the 7-bit immediate into the upper latch, flags untouched.
// - loading the accumulator literal puts the 8-bit immediate into the accumulator in one cycle, no flags.
// - storing the accumulator to a file writes it to the 7-bit file address in the selected bank, flags untouched, one cycle.
// - the indirect store writes the accumulator at pointer+1 (pre-inc), pointer-1 (pre-dec), the pointer itself (post modes) or pointer+signed offset (-32..31).
// - after the indirect store the pointer holds +1 for increments, -1 for decrements, unchanged for offset.
// - pointer_update_mode decodes 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - the indirect access port has no storage; accesses go to memory at the pointer's address.
// - each indirect pointer is 16 bits and wraps modulo 65536 on increment and decrement.
// - pointer increment and decrement never touch any status flag.

module lmis_core #(
    parameter int MEM_AW = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // memory must hold a full bank-and-file address, at most the pointer span
    generate
        if (MEM_AW < 12 || MEM_AW > 16)
        begin : g_bad_aw
            $error("lmis_core: MEM_AW must lie between 12 and 16");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // state

    lmis_pkg::lmis_wstate_e wstate;
    lmis_pkg::lmis_wstate_e next_wstate;
    logic aw_held;
    logic w_held;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [13:0] instr;
    logic [7:0] acc;
    logic [4:0] bank_select_reg;
    logic [6:0] program_counter_upper_latch;
    logic [15:0] indirect_pointer0;
    logic [15:0] indirect_pointer1;
    logic [2:0] flags;
    logic unsup;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata;
    lmis_pkg::lmis_decoded_s dec;
    lmis_pkg::lmis_mem_wr_s mem_wr;
    logic sw_write;
    logic exec_now;
    logic addr_ok;
    logic [15:0] sel_ptr;
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] ptr_ofs;
    logic [15:0] eff_addr;
    logic [15:0] next_ptr;
    logic ptr_update;

    // byte-lane merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel

    // address and data are taken independently, then applied together
    always_comb
    begin
        next_aw_held = aw_held | (s_axi_awvalid & s_axi_awready);
        next_w_held = w_held | (s_axi_wvalid & s_axi_wready);
        next_wstate = wstate;
        case (wstate)
            lmis_pkg::LMIS_WS_IDLE:
            begin
                if (aw_held && w_held)
                begin
                    next_wstate = (wr_addr == `LMIS_OFF_INSTR) ? lmis_pkg::LMIS_WS_EXEC : lmis_pkg::LMIS_WS_RESP;
                end
            end
            lmis_pkg::LMIS_WS_EXEC:
            begin
                next_wstate = lmis_pkg::LMIS_WS_RESP;
            end
            lmis_pkg::LMIS_WS_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_wstate = lmis_pkg::LMIS_WS_IDLE;
                    next_aw_held = 1'b0;
                    next_w_held = 1'b0;
                end
            end
            default:
            begin
                next_wstate = lmis_pkg::LMIS_WS_IDLE;
            end
        endcase
    end

    assign sw_write = (wstate == lmis_pkg::LMIS_WS_IDLE) && aw_held && w_held;
    assign exec_now = (wstate == lmis_pkg::LMIS_WS_EXEC);

    // write address decode for the response code
    always_comb
    begin
        case (wr_addr)
            `LMIS_OFF_INSTR, `LMIS_OFF_ACC, `LMIS_OFF_BANK, `LMIS_OFF_LATCH, `LMIS_OFF_PTR0,
            `LMIS_OFF_PTR1, `LMIS_OFF_STATUS, `LMIS_OFF_MEM_ADDR, `LMIS_OFF_MEM_DATA: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // handshake flops; readies drop while a write is held or answered
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wstate <= lmis_pkg::LMIS_WS_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LMIS_RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end
        else
        begin
            wstate <= next_wstate;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_awready <= (next_wstate == lmis_pkg::LMIS_WS_IDLE) && !next_aw_held;
            s_axi_wready <= (next_wstate == lmis_pkg::LMIS_WS_IDLE) && !next_w_held;
            s_axi_bvalid <= (next_wstate == lmis_pkg::LMIS_WS_RESP);
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (sw_write)
            begin
                s_axi_bresp <= addr_ok ? `LMIS_RESP_OKAY : `LMIS_RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode

    // fields are pulled from the word held in the instruction register
    always_comb
    begin
        dec = '0;
        dec.op = lmis_pkg::LMIS_OP_NONE;
        dec.file_addr = instr[6:0];
        if (instr[13:3] == `LMIS_IND_PATTERN)
        begin
            dec.op = lmis_pkg::LMIS_OP_IND;
            dec.ptr_sel = instr[`LMIS_IND_SEL_BIT];
            dec.mode = lmis_pkg::lmis_mode_e'(instr[1:0]);
        end
        else if (instr[13:7] == `LMIS_FILE_PATTERN)
        begin
            dec.op = lmis_pkg::LMIS_OP_FILE;
        end
        else if (instr[13:5] == `LMIS_BANK_PATTERN)
        begin
            dec.op = lmis_pkg::LMIS_OP_BANK;
            dec.literal = {3'h0, instr[4:0]};
        end
        else if (instr[13:7] == `LMIS_LATCH_PATTERN)
        begin
            dec.op = lmis_pkg::LMIS_OP_LATCH;
            dec.literal = {1'b0, instr[6:0]};
        end
        else if (instr[13:8] == `LMIS_ACC_PATTERN)
        begin
            dec.op = lmis_pkg::LMIS_OP_ACC;
            dec.literal = instr[7:0];
        end
        else if (instr[13:7] == `LMIS_OFS_PATTERN)
        begin
            dec.op = lmis_pkg::LMIS_OP_OFS;
            dec.ptr_sel = instr[`LMIS_OFS_SEL_BIT];
            dec.literal = {instr[5], instr[5], instr[5:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer arithmetic and effective address

    // 16-bit sums wrap on their own, which is the required roll-over
    assign sel_ptr = dec.ptr_sel ? indirect_pointer1 : indirect_pointer0;
    assign ptr_inc = sel_ptr + 16'h0001;
    assign ptr_dec = sel_ptr - 16'h0001;
    assign ptr_ofs = sel_ptr + {{8{dec.literal[7]}}, dec.literal};

    always_comb
    begin
        eff_addr = sel_ptr;
        next_ptr = sel_ptr;
        ptr_update = 1'b0;
        case (dec.op)
            lmis_pkg::LMIS_OP_IND:
            begin
                ptr_update = 1'b1;
                case (dec.mode)
                    lmis_pkg::LMIS_PRE_INC:
                    begin
                        eff_addr = ptr_inc;
                        next_ptr = ptr_inc;
                    end
                    lmis_pkg::LMIS_PRE_DEC:
                    begin
                        eff_addr = ptr_dec;
                        next_ptr = ptr_dec;
                    end
                    lmis_pkg::LMIS_POST_INC:
                    begin
                        next_ptr = ptr_inc;
                    end
                    default:
                    begin
                        next_ptr = ptr_dec;
                    end
                endcase
            end
            lmis_pkg::LMIS_OP_OFS:
            begin
                eff_addr = ptr_ofs;
            end
            lmis_pkg::LMIS_OP_FILE:
            begin
                // the port files redirect through their pointer, nothing is stored there
                if (dec.file_addr == `LMIS_PORT0_FILE)
                begin
                    eff_addr = indirect_pointer0;
                end
                else if (dec.file_addr == `LMIS_PORT1_FILE)
                begin
                    eff_addr = indirect_pointer1;
                end
                else
                begin
                    eff_addr = {4'h0, bank_select_reg, dec.file_addr};
                end
            end
            default:
            begin
                eff_addr = sel_ptr;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // architectural registers

    // instruction register; a write here launches one execute cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            instr <= `LMIS_RST_INSTR;
        end
        else if (sw_write && wr_addr == `LMIS_OFF_INSTR)
        begin
            instr <= 14'(merge({18'h0_0000, instr}, wr_data, wr_strb));
        end
    end

    // accumulator
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            acc <= `LMIS_RST_ACC;
        end
        else if (exec_now && dec.op == lmis_pkg::LMIS_OP_ACC)
        begin
            acc <= dec.literal;
        end
        else if (sw_write && wr_addr == `LMIS_OFF_ACC)
        begin
            acc <= 8'(merge({24'h00_0000, acc}, wr_data, wr_strb));
        end
    end

    // bank select and program latch
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bank_select_reg <= `LMIS_RST_BANK;
            program_counter_upper_latch <= `LMIS_RST_LATCH;
        end
        else
        begin
            if (exec_now && dec.op == lmis_pkg::LMIS_OP_BANK)
            begin
                bank_select_reg <= dec.literal[4:0];
            end
            else if (sw_write && wr_addr == `LMIS_OFF_BANK)
            begin
                bank_select_reg <= 5'(merge({27'h000_0000, bank_select_reg}, wr_data, wr_strb));
            end
            if (exec_now && dec.op == lmis_pkg::LMIS_OP_LATCH)
            begin
                program_counter_upper_latch <= dec.literal[6:0];
            end
            else if (sw_write && wr_addr == `LMIS_OFF_LATCH)
            begin
                program_counter_upper_latch <= 7'(merge({25'h000_0000, program_counter_upper_latch}, wr_data,
                    wr_strb));
            end
        end
    end

    // indirect pointers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            indirect_pointer0 <= `LMIS_RST_PTR;
            indirect_pointer1 <= `LMIS_RST_PTR;
        end
        else if (exec_now && ptr_update)
        begin
            if (dec.ptr_sel)
            begin
                indirect_pointer1 <= next_ptr;
            end
            else
            begin
                indirect_pointer0 <= next_ptr;
            end
        end
        else if (sw_write && wr_addr == `LMIS_OFF_PTR0)
        begin
            indirect_pointer0 <= 16'(merge({16'h0000, indirect_pointer0}, wr_data, wr_strb));
        end
        else if (sw_write && wr_addr == `LMIS_OFF_PTR1)
        begin
            indirect_pointer1 <= 16'(merge({16'h0000, indirect_pointer1}, wr_data, wr_strb));
        end
    end

    // status flags change only by software; unsup is rewritten on every execute cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            flags <= `LMIS_RST_FLAGS;
            unsup <= 1'b0;
        end
        else
        begin
            if (sw_write && wr_addr == `LMIS_OFF_STATUS && wr_strb[0])
            begin
                flags <= wr_data[`LMIS_ST_FLAGS_MSB:`LMIS_ST_FLAGS_LSB];
            end
            if (exec_now)
            begin
                unsup <= (dec.op == lmis_pkg::LMIS_OP_NONE);
            end
        end
    end

    // software window onto data memory
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mem_addr <= `LMIS_RST_MEM_ADDR;
        end
        else if (sw_write && wr_addr == `LMIS_OFF_MEM_ADDR)
        begin
            mem_addr <= 16'(merge({16'h0000, mem_addr}, wr_data, wr_strb));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data memory

    // one write per cycle: execute and software writes sit in different states
    always_comb
    begin
        mem_wr.en = 1'b0;
        mem_wr.addr = eff_addr;
        mem_wr.data = acc;
        if (exec_now && (dec.op == lmis_pkg::LMIS_OP_FILE || dec.op == lmis_pkg::LMIS_OP_IND ||
            dec.op == lmis_pkg::LMIS_OP_OFS))
        begin
            mem_wr.en = 1'b1;
        end
        else if (sw_write && wr_addr == `LMIS_OFF_MEM_DATA && wr_strb[0])
        begin
            mem_wr.en = 1'b1;
            mem_wr.addr = mem_addr;
            mem_wr.data = wr_data[7:0];
        end
    end

    lmis_mem #(
        .AW(MEM_AW),
        .DW(8)
    ) u_mem (
        .clk(ref_clk),
        .we(mem_wr.en),
        .waddr(mem_wr.addr[MEM_AW-1:0]),
        .wdata(mem_wr.data),
        .raddr(mem_addr[MEM_AW-1:0]),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel

    // one read in flight; data registered the edge after the address
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LMIS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `LMIS_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `LMIS_OFF_INSTR: s_axi_rdata <= {18'h0_0000, instr};
                `LMIS_OFF_ACC: s_axi_rdata <= {24'h00_0000, acc};
                `LMIS_OFF_BANK: s_axi_rdata <= {27'h000_0000, bank_select_reg};
                `LMIS_OFF_LATCH: s_axi_rdata <= {25'h000_0000, program_counter_upper_latch};
                `LMIS_OFF_PTR0: s_axi_rdata <= {16'h0000, indirect_pointer0};
                `LMIS_OFF_PTR1: s_axi_rdata <= {16'h0000, indirect_pointer1};
                `LMIS_OFF_STATUS: s_axi_rdata <= {23'h00_0000, unsup, 5'h00, flags};
                `LMIS_OFF_MEM_ADDR: s_axi_rdata <= {16'h0000, mem_addr};
                `LMIS_OFF_MEM_DATA: s_axi_rdata <= {24'h00_0000, mem_rdata};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `LMIS_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : lmis_core

// file: tb/lmis_core_props.sv
`timescale 1ns/100ps
module lmis_core_props #(
    parameter int MEM_AW = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read side
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // answers stand until taken, with no change
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    // one cycle from request to read answer
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    // a second write is refused while one is answered
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write not closed");
    // unmapped reads return zero data
    r_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("unmapped read data");
endmodule : lmis_core_props

bind lmis_core lmis_core_props #(.MEM_AW(MEM_AW)) chk_i (.ref_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: tb/literal_move_indirect_store_test.sv
`timescale 1ns/100ps
module literal_move_indirect_store_test;
    // bench signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] lit [3] = '{8'hff, 8'h00, 8'h5a};
    logic [15:0] base, ea, step;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;

    lmis_core #(.MEM_AW(12)) uut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid)
            @(posedge ref_clk);
        // answer is left waiting one cycle so that it must stand
        s_axi_bready <= 1'b1;
        @(posedge ref_clk);
        s_axi_bready <= 1'b0;
        chk({32'h0, s_axi_bresp}, {32'h0, er});
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge ref_clk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do
            @(posedge ref_clk);
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge ref_clk);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, {er, e});
    endtask : rc

    task automatic ex(input logic [13:0] w);
        wr(8'h00, {18'h0, w}, 2'h0);
    endtask : ex

    // data memory seen through the address and data window
    task automatic mc(input logic [15:0] a, input logic [7:0] e);
        wr(8'h1c, {16'h0, a}, 2'h0);
        rc(8'h20, {24'h0, e}, 2'h0);
    endtask : mc
    ////////////////////////////////////////
    // hang guard, far above the expected run
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim();
        end
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        wr(8'h18, 32'h5, 2'h0);
        // literal loads at top, bottom and middle values
        for (int i = 0; i < 3; i++)
        begin
            ex({9'h001, lit[i][4:0]});
            rc(8'h08, {27'h0, lit[i][4:0]}, 2'h0);
            ex({7'h63, lit[i][6:0]});
            rc(8'h0c, {25'h0, lit[i][6:0]}, 2'h0);
            ex({6'h30, lit[i]});
            rc(8'h04, {24'h0, lit[i]}, 2'h0);
            rc(8'h18, 32'h5, 2'h0);
        end
        // file store lands in the selected bank; address zero goes through pointer 0
        ex({9'h001, 5'h03});
        ex({7'h01, 7'h45});
        mc(16'h01c5, 8'h5a);
        wr(8'h10, 32'h0234, 2'h0);
        ex({7'h01, 7'h00});
        mc(16'h0234, 8'h5a);
        rc(8'h10, 32'h0234, 2'h0);
        // every update mode on both pointers; pointer 0 cases cross the wrap
        for (int i = 0; i < 8; i++)
        begin
            base = i[2] ? 16'h0800 : (i[0] ? 16'h0000 : 16'hffff);
            step = i[0] ? 16'hffff : 16'h0001;
            ea = i[1] ? base : base + step;
            ex({6'h30, 8'h10 + 8'(i)});
            wr(8'h10, {16'h0, base}, 2'h0);
            wr(8'h14, {16'h0, base}, 2'h0);
            ex({11'h003, i[2], i[1:0]});
            mc(ea, 8'h10 + 8'(i));
            rc(i[2] ? 8'h14 : 8'h10, {16'h0, 16'(base + step)}, 2'h0);
            rc(i[2] ? 8'h10 : 8'h14, {16'h0, base}, 2'h0);
            rc(8'h18, 32'h5, 2'h0);
        end
        // signed offset extremes leave the pointer alone
        wr(8'h14, 32'h0100, 2'h0);
        ex({7'h7f, 1'b1, 6'h20});
        mc(16'h00e0, 8'h17);
        ex({7'h7f, 1'b1, 6'h1f});
        mc(16'h011f, 8'h17);
        rc(8'h14, 32'h0100, 2'h0);
        // unknown word flags itself only; unmapped places refused
        ex(14'h2000);
        rc(8'h18, 32'h105, 2'h0);
        rc(8'h40, 32'h0, 2'h2);
        wr(8'h40, 32'h1, 2'h2);
        end_sim();
    end
endmodule : literal_move_indirect_store_test
